/* File: design/tmsr_pkg.sv */
// Constants for the thermal monitor register bank and its serial target.
// Assumes a 200 MHz core clock; offsets are the serial command byte values.
package tmsr_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_LOCAL_TEMP   = 8'h00;
  localparam logic [7:0] OFS_RMT_HI       = 8'h01;
  localparam logic [7:0] OFS_EVT_FLAGS    = 8'h02;
  localparam logic [7:0] OFS_MAIN_CFG     = 8'h03;
  localparam logic [7:0] OFS_CONV_RATE    = 8'h04;
  localparam logic [7:0] OFS_LOC_UPPER    = 8'h05;
  localparam logic [7:0] OFS_RMT_UPPER_HI = 8'h07;
  localparam logic [7:0] OFS_RMT_LOWER_HI = 8'h08;
  localparam logic [7:0] OFS_MAIN_CFG_A   = 8'h09;
  localparam logic [7:0] OFS_CONV_RATE_A  = 8'h0A;
  localparam logic [7:0] OFS_LOC_UPPER_A  = 8'h0B;
  localparam logic [7:0] OFS_RMT_UPPER_A  = 8'h0D;
  localparam logic [7:0] OFS_RMT_LOWER_A  = 8'h0E;
  localparam logic [7:0] OFS_ONE_SHOT     = 8'h0F;
  localparam logic [7:0] OFS_RMT_LO       = 8'h10;
  localparam logic [7:0] OFS_CORR_HI      = 8'h11;
  localparam logic [7:0] OFS_CORR_LO      = 8'h12;
  localparam logic [7:0] OFS_RMT_UPPER_LO = 8'h13;

  // ----------------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_MAIN_CFG     = 8'h00;
  localparam logic [7:0] RST_CONV_RATE    = 8'h08;
  localparam logic [7:0] RST_LOC_UPPER    = 8'h46;
  localparam logic [7:0] RST_RMT_UPPER_HI = 8'h55;
  localparam logic [7:0] RST_RMT_LOWER_HI = 8'h00;
  localparam logic [7:0] RST_CORR         = 8'h00;
  localparam logic [7:0] RST_RMT_UPPER_LO = 8'h00;
  localparam logic [7:0] MASK_MAIN_CFG    = 8'hE7;
  localparam logic [7:0] MASK_CONV_RATE   = 8'h0F;
  localparam logic [7:0] MASK_FRAC3       = 8'hE0;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_FAULT_FILTER_BIT = 0;  // consecutive_fault_filter_bit
  localparam int CFG_STANDBY_BIT      = 6;  // standby_select_bit
  localparam int FLG_BUSY             = 7;
  localparam int FLG_LOCAL_HIGH       = 6;
  localparam int FLG_REMOTE_HIGH      = 4;
  localparam int FLG_REMOTE_LOW       = 3;
  localparam int FLG_DIODE_FAULT      = 2;  // remote_diode_fault_flag

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CORE_PERIOD_NS   = 5;
  localparam int BUS_TIMEOUT_MS   = 25;
  localparam int BUS_TIMEOUT_CYC  =
    (BUS_TIMEOUT_MS * 1000000 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int CONV_LEN_CYC     = 16;
  localparam int FAULT_DEPTH      = 3;  // Consecutive out-of-limit results

endpackage

/* File: design/tmsr_regs.sv */
// Serial target and low register map of the thermal monitor.
// Assumes an external pull-up on the data line and an analog front end
// that presents its readings on the core clock.
//
// Behaviour
// RULE_01: With fault queue on, limit flags need three consecutive failing conversions.
// RULE_02: Fault queue starts off; software turns it on by writing 1.
// RULE_03: One-shot write in standby runs one conversion, then standby resumes.
// RULE_04: One-shot address stores nothing and always reads back zero.
// RULE_05: Either line held low past timeout returns the serial engine to idle.
// RULE_06: Master forcing timeout holds a line low at least 35 ms.
// RULE_07: Start condition anywhere aborts transfer; next byte is the address.
// RULE_08: Alias addresses reach the same storage as their primary addresses.
// RULE_09: Host never touches reserved or test locations.
// RULE_10: Remote filter adds no offset to the reported value.
// RULE_11: Bytes travel MSB first; a write carries one data byte.
// RULE_12: Local temperature is 8-bit two's complement, one degree per LSB.
// RULE_13: Remote value and upper limit are 11-bit, eighth degree, signed or unsigned.
// RULE_14: Filter select 00 none, 01 standard, 10 reserved, 11 clipped.
// RULE_15: Each conversion compares readings to limits and updates event flags.
// RULE_16: Remote low byte shows zero extra bits with filter and extension off.
`timescale 1ns/10ps
module tmsr_regs #(
  parameter logic [6:0] DEV_ADDR        = 7'h4C,
  parameter int         TIMEOUT_CYC     = tmsr_pkg::BUS_TIMEOUT_CYC,
  parameter int         CONV_PERIOD_CYC = 8000,
  parameter int         CLIP_STEP       = 256
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_smb_clk,
  input  wire logic        i_smb_dat,
  output logic             o_smb_dat,
  output logic             o_smb_dat_oe,
  input  wire logic [7:0]  i_local_temp,
  input  wire logic [12:0] i_remote_raw,
  input  wire logic        i_remote_diode_fault,
  input  wire logic [1:0]  i_remote_filter_select,
  input  wire logic        i_extended_resolution_enable,
  input  wire logic        i_unsigned_format,
  output logic             o_conv_start,
  output logic             o_busy,
  output logic             o_standby,
  output logic [7:0]       o_limit_flags
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
  } tmsr_state_t;
  localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
  localparam int PR_W = $clog2(CONV_PERIOD_CYC + 1);

  // ----------------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------------
  // Shift on serial clock rise; core reads it only after the 8th falling
  // edge, while the line is quiet, so the byte is stable when sampled.
  logic [7:0] rx_sh_q;
  always_ff @(posedge i_smb_clk) begin
    rx_sh_q <= {rx_sh_q[6:0], i_smb_dat};  // RULE_11
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers and line events
  // ----------------------------------------------------------------------
  logic scl_s1_q, scl_s2_q, scl_d3_q, sda_s1_q, sda_s2_q, sda_d3_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      {scl_s1_q, scl_s2_q, scl_d3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_d3_q} <= 3'h7;
    end else begin
      {scl_s1_q, scl_s2_q, scl_d3_q} <= {i_smb_clk, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_d3_q} <= {i_smb_dat, sda_s1_q, sda_s2_q};
    end
  end

  logic scl_rise, scl_fall, start_evt, stop_evt;
  assign scl_rise  = scl_s2_q & ~scl_d3_q;
  assign scl_fall  = ~scl_s2_q & scl_d3_q;
  assign start_evt = scl_s2_q & scl_d3_q & sda_d3_q & ~sda_s2_q;
  assign stop_evt  = scl_s2_q & scl_d3_q & ~sda_d3_q & sda_s2_q;

  // Low-line watchdog; saturates so a stuck bus keeps the engine idle
  logic [TO_W-1:0] to_cnt_q;
  logic            timeout;
  assign timeout = (to_cnt_q == TO_W'(TIMEOUT_CYC - 1));
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || (scl_s2_q && sda_s2_q)) begin
      to_cnt_q <= '0;
    end else if (!timeout) begin
      to_cnt_q <= to_cnt_q + 1'b1;  // RULE_05
    end
  end

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [7:0] cfg_q, rate_q, loc_up_q, rup_hi_q, rlo_hi_q;
  logic [7:0] corr_hi_q, corr_lo_q, rup_lo_q, local_q, flags_q;
  logic [12:0] rmt_val_q;
  logic [7:0] ptr_q, wdat_q, rd_val, rmt_lo_byte;
  logic       wr_stb_q, filt_on;

  assign filt_on = (i_remote_filter_select == 2'b01) ||
                   (i_remote_filter_select == 2'b11);  // RULE_14
  // Extra fractional bits only exist when filtering or extension is on
  assign rmt_lo_byte = (filt_on || i_extended_resolution_enable) ?
                       {rmt_val_q[4:0], 3'h0} :
                       {rmt_val_q[4:2], 5'h00};  // RULE_16

  // Read mux; unmapped and one-shot addresses answer zero
  always_comb begin
    rd_val = 8'h00;  // RULE_04
    if (ptr_q == tmsr_pkg::OFS_LOCAL_TEMP) begin
      rd_val = local_q;  // RULE_12
    end else if (ptr_q == tmsr_pkg::OFS_RMT_HI) begin
      rd_val = rmt_val_q[12:5];  // RULE_13
    end else if (ptr_q == tmsr_pkg::OFS_EVT_FLAGS) begin
      rd_val = flags_q;
    end else if (ptr_q == tmsr_pkg::OFS_MAIN_CFG ||
                 ptr_q == tmsr_pkg::OFS_MAIN_CFG_A) begin
      rd_val = cfg_q;  // RULE_08
    end else if (ptr_q == tmsr_pkg::OFS_CONV_RATE ||
                 ptr_q == tmsr_pkg::OFS_CONV_RATE_A) begin
      rd_val = rate_q;
    end else if (ptr_q == tmsr_pkg::OFS_LOC_UPPER ||
                 ptr_q == tmsr_pkg::OFS_LOC_UPPER_A) begin
      rd_val = loc_up_q;
    end else if (ptr_q == tmsr_pkg::OFS_RMT_UPPER_HI ||
                 ptr_q == tmsr_pkg::OFS_RMT_UPPER_A) begin
      rd_val = rup_hi_q;
    end else if (ptr_q == tmsr_pkg::OFS_RMT_LOWER_HI ||
                 ptr_q == tmsr_pkg::OFS_RMT_LOWER_A) begin
      rd_val = rlo_hi_q;
    end else if (ptr_q == tmsr_pkg::OFS_RMT_LO) begin
      rd_val = rmt_lo_byte;
    end else if (ptr_q == tmsr_pkg::OFS_CORR_HI) begin
      rd_val = corr_hi_q;
    end else if (ptr_q == tmsr_pkg::OFS_CORR_LO) begin
      rd_val = corr_lo_q;
    end else if (ptr_q == tmsr_pkg::OFS_RMT_UPPER_LO) begin
      rd_val = rup_lo_q;
    end
  end

  // Writes; aliases decode onto the same flip-flops
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      cfg_q     <= tmsr_pkg::RST_MAIN_CFG;  // RULE_02
      rate_q    <= tmsr_pkg::RST_CONV_RATE;
      loc_up_q  <= tmsr_pkg::RST_LOC_UPPER;
      rup_hi_q  <= tmsr_pkg::RST_RMT_UPPER_HI;
      rlo_hi_q  <= tmsr_pkg::RST_RMT_LOWER_HI;
      corr_hi_q <= tmsr_pkg::RST_CORR;
      corr_lo_q <= tmsr_pkg::RST_CORR;
      rup_lo_q  <= tmsr_pkg::RST_RMT_UPPER_LO;
    end else if (wr_stb_q) begin
      if (ptr_q == tmsr_pkg::OFS_MAIN_CFG ||
          ptr_q == tmsr_pkg::OFS_MAIN_CFG_A) begin
        cfg_q <= wdat_q & tmsr_pkg::MASK_MAIN_CFG;  // RULE_08
      end else if (ptr_q == tmsr_pkg::OFS_CONV_RATE ||
                   ptr_q == tmsr_pkg::OFS_CONV_RATE_A) begin
        rate_q <= wdat_q & tmsr_pkg::MASK_CONV_RATE;
      end else if (ptr_q == tmsr_pkg::OFS_LOC_UPPER ||
                   ptr_q == tmsr_pkg::OFS_LOC_UPPER_A) begin
        loc_up_q <= wdat_q;
      end else if (ptr_q == tmsr_pkg::OFS_RMT_UPPER_HI ||
                   ptr_q == tmsr_pkg::OFS_RMT_UPPER_A) begin
        rup_hi_q <= wdat_q;
      end else if (ptr_q == tmsr_pkg::OFS_RMT_LOWER_HI ||
                   ptr_q == tmsr_pkg::OFS_RMT_LOWER_A) begin
        rlo_hi_q <= wdat_q;
      end else if (ptr_q == tmsr_pkg::OFS_CORR_HI) begin
        corr_hi_q <= wdat_q;
      end else if (ptr_q == tmsr_pkg::OFS_CORR_LO) begin
        corr_lo_q <= wdat_q & tmsr_pkg::MASK_FRAC3;
      end else if (ptr_q == tmsr_pkg::OFS_RMT_UPPER_LO) begin
        rup_lo_q <= wdat_q & tmsr_pkg::MASK_FRAC3;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial target engine
  // ----------------------------------------------------------------------
  tmsr_state_t state_q, after_q;
  logic [3:0]  bitn_q;
  logic [7:0]  tx_q;
  logic        nack_q;
  // Start and timeout take precedence over any byte in flight
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      after_q <= ST_IDLE;
      bitn_q <= 4'h0;
      tx_q <= 8'h00;
      nack_q <= 1'b0;
      ptr_q <= 8'h00;
      wdat_q <= 8'h00;
      wr_stb_q <= 1'b0;
      o_smb_dat_oe <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (timeout) begin
        state_q <= ST_IDLE;  // RULE_05
        o_smb_dat_oe <= 1'b0;
      end else if (start_evt) begin
        state_q <= ST_ADDR;  // RULE_07
        bitn_q <= 4'h0;
        o_smb_dat_oe <= 1'b0;
      end else if (stop_evt) begin
        state_q <= ST_IDLE;
        o_smb_dat_oe <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise) begin
              bitn_q <= bitn_q + 4'h1;
            end else if (scl_fall && bitn_q == 4'h8) begin
              bitn_q <= 4'h0;
              o_smb_dat_oe <= 1'b1;
              state_q <= ST_ACK;
              if (state_q == ST_ADDR) begin
                after_q <= rx_sh_q[0] ? ST_RDATA : ST_CMD;
                if (rx_sh_q[7:1] != DEV_ADDR) begin
                  state_q <= ST_IDLE;
                  o_smb_dat_oe <= 1'b0;
                end
              end else if (state_q == ST_CMD) begin
                ptr_q <= rx_sh_q;
                after_q <= ST_WDATA;
              end else begin
                wdat_q <= rx_sh_q;
                wr_stb_q <= 1'b1;
                after_q <= ST_IDLE;  // RULE_11
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              state_q <= after_q;
              tx_q <= rd_val;
              o_smb_dat_oe <= (after_q == ST_RDATA) && !rd_val[7];
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bitn_q == 4'h7) begin
                bitn_q <= 4'h0;
                state_q <= ST_RACK;
                o_smb_dat_oe <= 1'b0;
              end else begin
                bitn_q <= bitn_q + 4'h1;
                tx_q <= {tx_q[6:0], 1'b0};
                o_smb_dat_oe <= !tx_q[6];  // RULE_11
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_s2_q;
            end else if (scl_fall) begin
              state_q <= nack_q ? ST_IDLE : ST_RDATA;
              tx_q <= rd_val;
              o_smb_dat_oe <= !nack_q && !rd_val[7];
            end
          end
          default: begin
            bitn_q <= 4'h0;
          end
        endcase
      end
    end
  end
  assign o_smb_dat = 1'b0;

  // ----------------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------------
  logic [PR_W-1:0] per_q;
  logic [4:0]      len_q;
  logic            busy_q, os_pend_q, conv_go, conv_done, os_wr;
  assign os_wr = wr_stb_q && (ptr_q == tmsr_pkg::OFS_ONE_SHOT);
  assign conv_go = !busy_q && (os_pend_q ||
                   (!cfg_q[tmsr_pkg::CFG_STANDBY_BIT] && per_q == '0));
  assign conv_done = busy_q && (len_q == 5'h01);
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      per_q <= '0;
      len_q <= 5'h00;
      busy_q <= 1'b0;
      os_pend_q <= 1'b0;
    end else begin
      // One-shot only meaningful in standby; the byte itself is dropped
      if (os_wr && cfg_q[tmsr_pkg::CFG_STANDBY_BIT]) begin
        os_pend_q <= 1'b1;  // RULE_03
      end else if (conv_go) begin
        os_pend_q <= 1'b0;
      end
      per_q <= (per_q == PR_W'(CONV_PERIOD_CYC - 1)) ? '0 : per_q + 1'b1;
      if (conv_go) begin
        busy_q <= 1'b1;
        len_q <= 5'(tmsr_pkg::CONV_LEN_CYC);
      end else if (conv_done) begin
        busy_q <= 1'b0;
        len_q <= 5'h00;
      end else if (busy_q) begin
        len_q <= len_q - 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Remote correction, filter and limit comparison
  // ----------------------------------------------------------------------
  logic signed [14:0] raw_x, corr_x, sum_x, clamp_x, filt_q, delta, step;
  logic [10:0] rem11, rup11, rlo11;
  logic        loc_hi_c, rmt_hi_c, rmt_lo_c, fq_on;
  logic [1:0]  lh_cnt_q, rh_cnt_q, rl_cnt_q;
  assign fq_on = cfg_q[tmsr_pkg::CFG_FAULT_FILTER_BIT];

  always_comb begin
    raw_x = i_unsigned_format ? $signed({2'b00, i_remote_raw}) :
            $signed({{2{i_remote_raw[12]}}, i_remote_raw});
    corr_x = $signed({{2{corr_hi_q[7]}}, corr_hi_q, corr_lo_q[7:5], 2'b00});
    sum_x = raw_x + corr_x;
    clamp_x = sum_x;
    // Clamp instead of wrapping at full scale
    if (i_unsigned_format) begin
      if (sum_x < 0) clamp_x = 15'sd0;
      else if (sum_x > 15'sd8191) clamp_x = 15'sd8191;
    end else begin
      if (sum_x < -15'sd4096) clamp_x = -15'sd4096;
      else if (sum_x > 15'sd4095) clamp_x = 15'sd4095;
    end
    // Rounded quarter step keeps the filter free of a bias
    delta = clamp_x - filt_q;
    if (i_remote_filter_select == 2'b11) begin  // RULE_14
      if (delta > 15'(CLIP_STEP)) delta = 15'(CLIP_STEP);
      else if (delta < -15'(CLIP_STEP)) delta = -15'(CLIP_STEP);
    end
    step = (delta + 15'sd2) >>> 2;  // RULE_10
    rem11 = rmt_val_q[12:2];
    rup11 = {rup_hi_q, rup_lo_q[7:5]};  // RULE_13
    rlo11 = {rlo_hi_q, 3'h0};
    rmt_hi_c = i_unsigned_format ? (rem11 > rup11) :
               ($signed(rem11) > $signed(rup11));
    rmt_lo_c = i_unsigned_format ? (rem11 < rlo11) :
               ($signed(rem11) < $signed(rlo11));
    loc_hi_c = $signed(local_q) > $signed(loc_up_q);  // RULE_12
  end

  // Readings latch at conversion end; flags follow one cycle later
  logic cmp_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      filt_q <= 15'sd0;
      rmt_val_q <= 13'h0000;
      local_q <= 8'h00;
      cmp_q <= 1'b0;
    end else begin
      cmp_q <= conv_done;
      if (conv_done) begin
        local_q <= i_local_temp;
        filt_q <= filt_on ? (filt_q + step) : clamp_x;
        rmt_val_q <= filt_on ? 13'(filt_q + step) : 13'(clamp_x);
      end
    end
  end

  // Fault queue counters saturate at 3, the full depth
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      {lh_cnt_q, rh_cnt_q, rl_cnt_q} <= 6'h00;
      flags_q <= 8'h00;
    end else begin
      flags_q[tmsr_pkg::FLG_BUSY] <= busy_q;
      if (cmp_q) begin
        lh_cnt_q <= loc_hi_c ? lh_cnt_q + {1'b0, lh_cnt_q != 2'h3} : 2'h0;
        rh_cnt_q <= rmt_hi_c ? rh_cnt_q + {1'b0, rh_cnt_q != 2'h3} : 2'h0;
        rl_cnt_q <= rmt_lo_c ? rl_cnt_q + {1'b0, rl_cnt_q != 2'h3} : 2'h0;
        flags_q[tmsr_pkg::FLG_LOCAL_HIGH] <= loc_hi_c &&
          (!fq_on || lh_cnt_q >= 2'(tmsr_pkg::FAULT_DEPTH - 1));  // RULE_01
        flags_q[tmsr_pkg::FLG_REMOTE_HIGH] <= rmt_hi_c &&
          (!fq_on || rh_cnt_q >= 2'(tmsr_pkg::FAULT_DEPTH - 1));  // RULE_15
        flags_q[tmsr_pkg::FLG_REMOTE_LOW] <= rmt_lo_c &&
          (!fq_on || rl_cnt_q >= 2'(tmsr_pkg::FAULT_DEPTH - 1));
        flags_q[tmsr_pkg::FLG_DIODE_FAULT] <= i_remote_diode_fault;
      end
    end
  end

  assign o_conv_start = conv_go;
  assign o_busy = busy_q;
  assign o_standby = cfg_q[tmsr_pkg::CFG_STANDBY_BIT];
  assign o_limit_flags = flags_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_fault_queue;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (fq_on && $rose(flags_q[tmsr_pkg::FLG_LOCAL_HIGH])) |->
      $past(lh_cnt_q) >= 2'h2;
  endproperty
  a_fault_queue: assert property (p_fault_queue)  // RULE_01
    else $error("local high flag set before three failing conversions");

  property p_fq_reset_off;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !$past(i_reset_n) |-> !fq_on;
  endproperty
  a_fq_reset_off: assert property (p_fq_reset_off)  // RULE_02
    else $error("fault queue enabled after reset");

  property p_one_shot;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (os_wr && o_standby && !busy_q && !os_pend_q) |=>
      conv_go ##1 busy_q ##15 conv_done ##1 (!busy_q && !os_pend_q);
  endproperty
  a_one_shot: assert property (p_one_shot)  // RULE_03
    else $error("one-shot did not run exactly one conversion");

  property p_one_shot_zero;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == ST_ACK && scl_fall && after_q == ST_RDATA &&
     ptr_q == tmsr_pkg::OFS_ONE_SHOT) |=> (tx_q == 8'h00);
  endproperty
  a_one_shot_zero: assert property (p_one_shot_zero)  // RULE_04
    else $error("one-shot address read back nonzero");

  property p_timeout;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    timeout |=> (state_q == ST_IDLE) && !o_smb_dat_oe;
  endproperty
  a_timeout: assert property (p_timeout)  // RULE_05
    else $error("engine not idle after bus timeout");

  property p_start;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (start_evt && !timeout) |=> (state_q == ST_ADDR) && (bitn_q == 4'h0);
  endproperty
  a_start: assert property (p_start)  // RULE_07
    else $error("start condition did not restart address phase");

  property p_alias;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (wr_stb_q && ptr_q == tmsr_pkg::OFS_MAIN_CFG_A) |=>
      cfg_q == ($past(wdat_q) & tmsr_pkg::MASK_MAIN_CFG);
  endproperty
  a_alias: assert property (p_alias)  // RULE_08
    else $error("alias write missed the shared register");

  property p_msb_first;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == ST_RDATA) |-> (o_smb_dat_oe == !tx_q[7]);
  endproperty
  a_msb_first: assert property (p_msb_first)  // RULE_11
    else $error("read data not shifted out MSB first");

  property p_compare;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (cmp_q && !fq_on) |=>
      flags_q[tmsr_pkg::FLG_REMOTE_HIGH] == $past(rmt_hi_c);
  endproperty
  a_compare: assert property (p_compare)  // RULE_15
    else $error("remote high flag disagrees with comparison");

  property p_low_byte;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (!filt_on && !i_extended_resolution_enable) |->
      (rmt_lo_byte[4:0] == 5'h00);
  endproperty
  a_low_byte: assert property (p_low_byte)  // RULE_16
    else $error("extra fraction bits shown while filter is off");

endmodule  // tmsr_regs

/* File: sim/tmsr_host_model.sv */
// Host master model for the serial target of the register bank.
// Assumes an open-drain data line with a pull-up and an 80 ns bus clock.
`timescale 1ns/10ps
module tmsr_host_model (
  input  wire logic i_dat_oe,
  output logic      o_smb_clk,
  output logic      o_smb_dat
);
  logic low_q = 1'b0;
  logic r;
  // Wired line: high through the pull-up unless either side pulls
  assign o_smb_dat = ~(low_q | i_dat_oe);
  initial o_smb_clk = 1'b1;
  // -----------------------------------------------------------------
  // Bit level; data moves only while the clock is low, except in start and stop
  // -----------------------------------------------------------------
  task automatic bit_io(input logic b, output logic s);
    low_q = ~b;
    #20 o_smb_clk = 1'b1;
    #20 s = o_smb_dat;
    #20 o_smb_clk = 1'b0;
    #20;
  endtask
  // Odd offset keeps bus edges off the core clock edges
  task automatic start();
    low_q = 1'b0;
    #23 o_smb_clk = 1'b1;
    #20 low_q = 1'b1;
    #20 o_smb_clk = 1'b0;
    #20;
  endtask
  task automatic stop();
    low_q = 1'b1;
    #20 o_smb_clk = 1'b1;
    #20 low_q = 1'b0;
    #40;
  endtask
  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
  endtask
  // Single byte reads end with no-acknowledge
  task automatic read_reg(input logic [7:0] c, output logic [7:0] v);
    start();
    send(8'h98);
    send(c);
    start();
    send(8'h99);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(1'b1, r);
    stop();
  endtask
  // One data byte per write, mapped places only
  task automatic write_reg(input logic [7:0] c, d);
    start();
    send(8'h98);
    send(c);
    send(d);
    stop();
  endtask
endmodule // tmsr_host_model

/* File: sim/tmsr_regs_bench.sv */
// Self-checking bench for the thermal monitor register bank.
// Assumes the host model drives the serial pins through its tasks.
`timescale 1ns/10ps
module tmsr_regs_bench;
  localparam logic [7:0] CMD [14] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h08,
    8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h0F, 8'h11, 8'h12, 8'h13};
  localparam logic [7:0] EXP [14] = '{8'h00, 8'h08, 8'h46, 8'h55, 8'h00,
    8'h00, 8'h08, 8'h46, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic       core_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       smb_clk, smb_dat, dat_oe, busy, busy_q, standby, b;
  logic [7:0] temp = 8'h19;
  logic [7:0] flags, rd;
  logic       dfault = 1'b0, ext = 1'b0, go;
  logic [1:0] fsel = 2'h0;
  logic [12:0] raw = 13'h0320;
  int         starts = 0;
  int         miscompares = 0;
  int         check_count = 0;
  int         cycles = 0;
  int         rises = 0;
  tmsr_regs #(.TIMEOUT_CYC(2000)) i_tmsr_regs (
    .i_core_clk(core_clk), .i_reset_n(reset_n), .i_smb_clk(smb_clk),
    .i_smb_dat(smb_dat), .o_smb_dat(), .o_smb_dat_oe(dat_oe),
    .i_local_temp(temp), .i_remote_raw(raw),
    .i_remote_diode_fault(dfault), .i_remote_filter_select(fsel),
    .i_extended_resolution_enable(ext), .i_unsigned_format(1'b0),
    .o_conv_start(go), .o_busy(busy), .o_standby(standby),
    .o_limit_flags(flags));
  tmsr_host_model i_tmsr_host_model (.i_dat_oe(dat_oe),
    .o_smb_clk(smb_clk), .o_smb_dat(smb_dat));
  initial forever #2.5 core_clk = ~core_clk;
  // Busy rises count conversions; cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    busy_q <= busy;
    if (busy === 1'b1 && busy_q !== 1'b1) rises <= rises + 1;
    if (go === 1'b1) starts <= starts + 1;
    if (cycles == 60000) begin
      miscompares++;
      results();
    end
  end
  // -----------------------------------------------------------------
  // Checks and scenarios
  // -----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] c, exp);
    // Realign so bus edges never land on core clock edges
    @(posedge core_clk);
    i_tmsr_host_model.read_reg(c, rd);
    chk(rd, exp);
  endtask
  // Exactly one conversion per one-shot, standby kept afterwards
  task automatic one_shot(input logic exp);
    int n, m;
    n = rises;
    m = starts;
    i_tmsr_host_model.write_reg(8'h0F, 8'h00);
    repeat (40) @(posedge core_clk);
    chk(8'(rises - n), 8'h01);
    chk(8'(starts - m), 8'h01);
    chk({7'h0, flags[6]}, {7'h0, exp});
    chk({7'h0, standby}, 8'h01);
  endtask
  task automatic t_alias();
    i_tmsr_host_model.write_reg(8'h0B, 8'h5A);
    rd_chk(8'h05, 8'h5A);
    i_tmsr_host_model.write_reg(8'h08, 8'h12);
    rd_chk(8'h0E, 8'h12);
    i_tmsr_host_model.write_reg(8'h0F, 8'hFF);
    rd_chk(8'h0F, 8'h00);
  endtask
  // Start in mid data byte must drop the half-sent write
  task automatic t_abort();
    i_tmsr_host_model.start();
    i_tmsr_host_model.send(8'h98);
    i_tmsr_host_model.send(8'h05);
    repeat (4) i_tmsr_host_model.bit_io(1'b0, b);
    i_tmsr_host_model.write_reg(8'h07, 8'h33);
    rd_chk(8'h05, 8'h5A);
    rd_chk(8'h07, 8'h33);
  endtask
  task automatic t_fault();
    i_tmsr_host_model.write_reg(8'h03, 8'h40);
    @(posedge core_clk) temp <= 8'h60;
    one_shot(1'b1);
    @(posedge core_clk) temp <= 8'h19;
    one_shot(1'b0);
    i_tmsr_host_model.write_reg(8'h09, 8'h41);
    @(posedge core_clk) temp <= 8'h60;
    repeat (2) one_shot(1'b0);
    one_shot(1'b1);
  endtask
  // Clock stalled low while the target drives a zero
  task automatic t_timeout();
    i_tmsr_host_model.start();
    i_tmsr_host_model.send(8'h99);
    chk({7'h0, dat_oe}, 8'h01);
    #12001;
    chk({7'h0, dat_oe}, 8'h00);
    i_tmsr_host_model.stop();
    rd_chk(8'h03, 8'h41);
  endtask
  // Remote readback and diode flag; a settled filter adds no offset
  task automatic t_remote();
    @(posedge core_clk) raw <= 13'h0327;
    dfault <= 1'b1;
    one_shot(1'b1);
    rd_chk(8'h00, 8'h60);
    rd_chk(8'h01, 8'h19);
    rd_chk(8'h10, 8'h20);
    rd_chk(8'h02, 8'h44);
    @(posedge core_clk) ext <= 1'b1;
    rd_chk(8'h10, 8'h38);
    @(posedge core_clk) {ext, fsel} <= 3'h1;
    one_shot(1'b1);
    rd_chk(8'h10, 8'h38);
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    for (int i = 0; i < 14; i++) rd_chk(CMD[i], EXP[i]);
    t_alias();
    t_abort();
    t_fault();
    t_timeout();
    t_remote();
    results();
  end
endmodule // tmsr_regs_bench
